/* File: rtl/acc_comparator_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module acc_comparator_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        cmp_raw,
	input  wire logic        timer_clk,
	input  wire logic [5:0]  port_pins_in,
	output var  logic [5:0]  port_pins_out,
	output var  logic [5:0]  port_pins_oe,
	output var  logic        cmp_power_on,
	output var  logic        cmp_speed_normal,
	output var  logic        cmp_hysteresis_on,
	output var  logic [3:0]  pos_src_enable,
	output var  logic [2:0]  neg_src_enable,
	output var  logic        result_synchronized,
	output var  logic        result_unsynchronized,
	output var  logic        timer_gate_source,
	output var  logic        comparator_irq_flag
);
	import acc_pkg::*;

	// Pin that carries the comparator result
	localparam int unsigned RESULT_PIN = 2;

	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl1_reg;
	logic [5:0] port_latch_reg;
	logic [5:0] pin_dir_reg;
	logic [5:0] pin_ana_reg;
	logic       irq_flag_reg;
	logic       result_reg;
	logic       result_prev_reg;
	logic       raw_sync;
	logic       timer_latched;
	logic       result_comb;
	logic       pin_drive;
	logic       wr_en;
	logic       rd_en;
	logic       rise_evt;
	logic       fall_evt;
	logic       addr_ok;
	logic [5:0] port_read;
	logic [31:0] rdata_next;

	wire enable_bit = ctrl0_reg[C0_ENABLE];
	wire invert_bit = ctrl0_reg[C0_INVERT];
	wire oe_bit     = ctrl0_reg[C0_OE];
	wire sync_bit   = ctrl0_reg[C0_SYNC];
	wire [1:0] pch  = ctrl1_reg[C1_PCH_LO +: 2];
	wire [2:0] nch  = ctrl1_reg[C1_NCH_LO +: 3];

	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && !penable && !pwrite;

	acc_sync2 u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (cmp_raw),
		.q       (raw_sync)
	);

	// Disabled comparator reads low before polarity
	assign result_comb = (enable_bit & raw_sync) ^ invert_bit;

	acc_timer_latch u_tlatch (
		.pclk      (pclk),
		.presetn   (presetn),
		.timer_clk (timer_clk),
		.d         (result_comb),
		.q         (timer_latched)
	);

	always_comb begin
		addr_ok = 1'b1;
		case (paddr)
			ADDR_CTRL0, ADDR_CTRL1, ADDR_MIRROR, ADDR_IRQ, ADDR_PORT, ADDR_PINCFG: begin
				addr_ok = 1'b1;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !addr_ok;
		end
	end

	// Control register zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_reg <= CTRL0_RESET;
		end else if (wr_en && paddr == ADDR_CTRL0 && pstrb[0]) begin
			ctrl0_reg <= (pwdata[7:0] & CTRL0_WMASK) | (ctrl0_reg & ~CTRL0_WMASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl1_reg <= CTRL1_RESET;
		end else if (wr_en && paddr == ADDR_CTRL1 && pstrb[0]) begin
			ctrl1_reg <= pwdata[7:0] & CTRL1_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_latch_reg <= '0;
		end else if (wr_en && paddr == ADDR_PORT && pstrb[0]) begin
			port_latch_reg <= pwdata[5:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_dir_reg <= PIN_DIR_RESET;
			pin_ana_reg <= PIN_ANA_RESET;
		end else if (wr_en && paddr == ADDR_PINCFG) begin
			if (pstrb[0]) begin
				pin_dir_reg <= pwdata[5:0];
			end
			if (pstrb[1]) begin
				pin_ana_reg <= pwdata[13:8];
			end
		end
	end

	// Internal result registered once per cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_reg <= 1'b0;
		end else begin
			result_reg <= result_comb;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_prev_reg <= 1'b0;
		end else begin
			result_prev_reg <= result_reg;
		end
	end

	assign rise_evt = result_reg && !result_prev_reg && ctrl1_reg[C1_RISE];
	assign fall_evt = !result_reg && result_prev_reg && ctrl1_reg[C1_FALL];

	// Set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_flag_reg <= 1'b0;
		end else if (rise_evt || fall_evt) begin
			irq_flag_reg <= 1'b1;
		end else if (wr_en && paddr == ADDR_IRQ && pstrb[0] && pwdata[0]) begin
			irq_flag_reg <= 1'b0;
		end
	end

	// Analog pins read zero
	assign port_read = port_pins_in & ~pin_ana_reg;

	always_comb begin
		rdata_next = '0;
		case (paddr)
			ADDR_CTRL0: begin
				rdata_next[7:0] = ctrl0_reg;
				rdata_next[C0_RESULT] = result_reg;
			end
			ADDR_CTRL1: begin
				rdata_next[7:0] = ctrl1_reg;
			end
			ADDR_MIRROR: begin
				rdata_next[0] = result_reg;
			end
			ADDR_IRQ: begin
				rdata_next[0] = irq_flag_reg;
			end
			ADDR_PORT: begin
				rdata_next[5:0] = port_read;
			end
			ADDR_PINCFG: begin
				rdata_next[5:0]  = pin_dir_reg;
				rdata_next[13:8] = pin_ana_reg;
			end
			default: begin
				rdata_next = '0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_en) begin
			prdata <= rdata_next;
		end
	end

	// Pin side uses unregistered result, or timer-latched in sync mode
	assign pin_drive = sync_bit ? timer_latched : result_comb;

	generate
		for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					port_pins_out[i] <= 1'b0;
					port_pins_oe[i]  <= 1'b0;
				end else if (i == RESULT_PIN && oe_bit) begin
					port_pins_out[i] <= pin_drive;
					port_pins_oe[i]  <= !pin_dir_reg[i] && enable_bit;
				end else begin
					port_pins_out[i] <= port_latch_reg[i];
					port_pins_oe[i]  <= !pin_dir_reg[i];
				end
			end
		end
	endgenerate

	// Analog control and source selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_power_on <= 1'b0;
		end else begin
			cmp_power_on <= enable_bit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_speed_normal <= 1'b1;
		end else begin
			cmp_speed_normal <= ctrl0_reg[C0_SPEED];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_hysteresis_on <= 1'b0;
		end else begin
			cmp_hysteresis_on <= ctrl0_reg[C0_HYST];
		end
	end

	// Sources left open while the comparator is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_src_enable <= '0;
		end else if (!enable_bit) begin
			pos_src_enable <= '0;
		end else begin
			case (pch)
				ACC_PCH_PIN: pos_src_enable <= 4'h1;
				ACC_PCH_DAC: pos_src_enable <= 4'h2;
				ACC_PCH_REF: pos_src_enable <= 4'h4;
				ACC_PCH_GND: pos_src_enable <= 4'h8;
				default:     pos_src_enable <= 4'h0;
			endcase
		end
	end

	// Reserved codes leave the inverting input open
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			neg_src_enable <= '0;
		end else if (!enable_bit) begin
			neg_src_enable <= '0;
		end else begin
			case (nch)
				ACC_NCH_PIN0: neg_src_enable <= 3'h1;
				ACC_NCH_PIN1: neg_src_enable <= 3'h2;
				ACC_NCH_REF:  neg_src_enable <= 3'h4;
				default:      neg_src_enable <= 3'h0;
			endcase
		end
	end

	// Result routing to peripherals
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_synchronized <= 1'b0;
		end else begin
			result_synchronized <= sync_bit ? timer_latched : result_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_unsynchronized <= 1'b0;
		end else begin
			result_unsynchronized <= result_comb;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_gate_source <= 1'b0;
		end else begin
			timer_gate_source <= sync_bit ? timer_latched : result_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comparator_irq_flag <= 1'b0;
		end else begin
			comparator_irq_flag <= irq_flag_reg;
		end
	end
endmodule // acc_comparator_ctrl
`default_nettype wire

/* File: rtl/acc_pkg.sv */
package acc_pkg;
	// Register byte addresses on the APB
	localparam logic [11:0] ADDR_CTRL0   = 12'h000;
	localparam logic [11:0] ADDR_CTRL1   = 12'h004;
	localparam logic [11:0] ADDR_MIRROR  = 12'h008;
	localparam logic [11:0] ADDR_IRQ     = 12'h00C;
	localparam logic [11:0] ADDR_PORT    = 12'h010;
	localparam logic [11:0] ADDR_PINCFG  = 12'h014;

	// Control register zero fields
	localparam int unsigned C0_ENABLE = 7;
	localparam int unsigned C0_RESULT = 6;
	localparam int unsigned C0_OE     = 5;
	localparam int unsigned C0_INVERT = 4;
	localparam int unsigned C0_SPEED  = 2;
	localparam int unsigned C0_HYST   = 1;
	localparam int unsigned C0_SYNC   = 0;

	// Control register one fields
	localparam int unsigned C1_RISE   = 7;
	localparam int unsigned C1_FALL   = 6;
	localparam int unsigned C1_PCH_LO = 4;
	localparam int unsigned C1_NCH_LO = 0;

	// Pin configuration fields
	localparam int unsigned PC_DIR    = 0;
	localparam int unsigned PC_ANALOG = 1;

	localparam int unsigned NUM_PINS  = 6;

	localparam logic [7:0] CTRL0_RESET = 8'h04;
	localparam logic [7:0] CTRL1_RESET = 8'h00;
	localparam logic [7:0] CTRL0_WMASK = 8'hB7;
	localparam logic [7:0] CTRL1_WMASK = 8'hF7;
	localparam logic [5:0] PIN_DIR_RESET = 6'h3F;
	localparam logic [5:0] PIN_ANA_RESET = 6'h00;

	typedef enum logic [1:0] {
		ACC_PCH_PIN = 2'b00,
		ACC_PCH_DAC = 2'b01,
		ACC_PCH_REF = 2'b10,
		ACC_PCH_GND = 2'b11
	} acc_pch_t;

	typedef enum logic [2:0] {
		ACC_NCH_PIN0 = 3'b000,
		ACC_NCH_PIN1 = 3'b001,
		ACC_NCH_REF  = 3'b100
	} acc_nch_t;

	// Analog mux one-hot source enables
	localparam int unsigned PSRC_W = 4;
	localparam int unsigned NSRC_W = 3;
endpackage : acc_pkg

/* File: rtl/acc_sync2.sv */
`timescale 1ns/10ps
`default_nettype none
module acc_sync2 (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic d,
	output var  logic q
);
	logic stage1_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1_reg <= 1'b0;
			q          <= 1'b0;
		end else begin
			stage1_reg <= d;
			q          <= stage1_reg;
		end
	end
endmodule // acc_sync2
`default_nettype wire

/* File: rtl/acc_timer_latch.sv */
`timescale 1ns/10ps
`default_nettype none
// Catches the result at each falling edge of the timer tick input
module acc_timer_latch (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic timer_clk,
	input  wire logic d,
	output var  logic q
);
	logic tclk_prev_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tclk_prev_reg <= 1'b0;
			q             <= 1'b0;
		end else begin
			tclk_prev_reg <= timer_clk;
			if (tclk_prev_reg && !timer_clk) begin
				q <= d;
			end
		end
	end
endmodule // acc_timer_latch
`default_nettype wire

/* File: test/acc_analog_model.sv */
`timescale 1ns/10ps
`default_nettype none
module acc_analog_model (
	input  wire logic        pclk,
	input  wire logic [3:0]  pos_src_enable,
	input  wire logic [2:0]  neg_src_enable,
	input  wire logic [23:0] pos_lv,
	input  wire logic [23:0] neg_lv,
	output var  logic        cmp_raw
);
	logic [7:0] vp, vn;
	logic       junk = 1'b0;
	always @(posedge pclk) junk <= ~junk;
	always_comb begin
		vp = 8'h00;
		vn = 8'h00;
		for (int i = 0; i < 3; i++) begin
			if (pos_src_enable[i]) vp = pos_lv[8*i+:8];
			if (neg_src_enable[i]) vn = neg_lv[8*i+:8];
		end
	end
	// Open inputs give a wandering decision
	assign cmp_raw = (!pos_src_enable || !neg_src_enable) ? junk : vp > vn;
endmodule // acc_analog_model
`default_nettype wire

/* File: test/acc_comparator_ctrl_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module acc_comparator_ctrl_tb_top;
	import acc_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic        pready, pslverr, perr, cmp_raw, timer_clk = 1'b1, flag, rs, ru, tg, pwr, spd, hys;
	logic [5:0]  pin_in = 6'h3F, pin_out, pin_oe;
	logic [3:0]  pse;
	logic [2:0]  nse;
	logic [23:0] plv = 24'h0, nlv = 24'h0;
	int          error_cnt = 0, checks = 0;
	always #2.5 pclk = ~pclk;
	acc_comparator_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hF), .prdata, .pready, .pslverr, .cmp_raw, .timer_clk, .port_pins_in(pin_in),
		.port_pins_out(pin_out), .port_pins_oe(pin_oe), .cmp_power_on(pwr),
		.cmp_speed_normal(spd), .cmp_hysteresis_on(hys), .pos_src_enable(pse),
		.neg_src_enable(nse), .result_synchronized(rs), .result_unsynchronized(ru),
		.timer_gate_source(tg), .comparator_irq_flag(flag));
	acc_analog_model u_src (.pclk, .pos_src_enable(pse), .neg_src_enable(nse), .pos_lv(plv),
		.neg_lv(nlv), .cmp_raw);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdv = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask
	task automatic wt(input int n); repeat (n) @(posedge pclk); endtask
	task automatic t_reset;
		chk(32'({pin_oe, spd}), 32'h1);
		rd(ADDR_CTRL0, 32'h04);
		rd(12'h0FC, 32'h0);
		chk(32'(perr), 32'h1);
		$display("reset test done");
	endtask
	task automatic t_chan;
		int nc[4] = '{0, 1, 4, 2};
		int ne[4] = '{1, 2, 4, 0};
		wr(ADDR_CTRL0, 32'h86);
		wt(2);
		chk(32'({pwr, hys}), 32'h3);
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_CTRL1, 32'(p) << 4);
			wt(2);
			chk(32'(pse), 32'h1 << p);
		end
		for (int n = 0; n < 4; n++) begin
			wr(ADDR_CTRL1, 32'(nc[n]));
			wt(2);
			chk(32'(nse), 32'(ne[n]));
		end
		wr(ADDR_CTRL0, 32'h00);
		wt(2);
		chk(32'({pwr, pse, nse}), 32'h0);
		chk(32'(spd), 32'h0);
		$display("channel test done");
	endtask
	task automatic t_pol;
		plv <= 24'h000080;
		nlv <= 24'h000040;
		wr(ADDR_CTRL1, 32'h0);
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_CTRL0, i ? 32'h94 : 32'h84);
			wt(8);
			rd(ADDR_CTRL0, i ? 32'h94 : 32'hC4);
			rd(ADDR_MIRROR, 32'(1 - i));
			chk(32'({rs, ru}), i ? 32'h0 : 32'h3);
		end
		$display("polarity test done");
	endtask
	task automatic t_pin;
		wr(ADDR_PORT, 32'h3B);
		wr(ADDR_PINCFG, 32'h3B);
		wr(ADDR_CTRL0, 32'hA4);
		wt(8);
		chk(32'({pin_oe[2], pin_out[2]}), 32'h3);
		chk(32'({pin_oe, pin_out}), 32'h13F);
		wr(ADDR_PINCFG, 32'h3F);
		wt(2);
		chk(32'(pin_oe[2]), 32'h0);
		wr(ADDR_PINCFG, 32'h3B);
		wr(ADDR_CTRL0, 32'h24);
		wt(2);
		chk(32'(pin_oe[2]), 32'h0);
		$display("pin test done");
	endtask
	task automatic t_irq;
		wr(ADDR_CTRL1, 32'h80);
		plv <= 24'h000010;
		wr(ADDR_CTRL0, 32'h84);
		wt(8);
		wr(ADDR_IRQ, 32'h1);
		wt(2);
		chk(32'(flag), 32'h0);
		plv <= 24'h000080;
		wt(8);
		chk(32'(flag), 32'h1);
		wr(ADDR_IRQ, 32'h1);
		plv <= 24'h000010;
		wt(8);
		chk(32'(flag), 32'h0);
		wr(ADDR_CTRL1, 32'h40);
		plv <= 24'h000080;
		wt(8);
		chk(32'(flag), 32'h0);
		plv <= 24'h000010;
		wt(8);
		chk(32'(flag), 32'h1);
		$display("edge flag test done");
	endtask
	task automatic t_sync;
		timer_clk <= 1'b0;
		wt(4);
		timer_clk <= 1'b1;
		wr(ADDR_CTRL0, 32'h85);
		plv <= 24'h000080;
		wt(8);
		chk(32'({rs, tg}), 32'h0);
		timer_clk <= 1'b0;
		wt(4);
		chk(32'({rs, tg}), 32'h3);
		$display("sync test done");
	endtask
	task automatic t_port;
		wr(ADDR_PINCFG, 32'h3F3F);
		wt(3);
		rd(ADDR_PORT, 32'h0);
		wr(ADDR_PINCFG, 32'h3F);
		wt(3);
		rd(ADDR_PORT, 32'h3F);
		$display("port test done");
	endtask
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_chan;
		t_pol;
		t_pin;
		t_irq;
		t_sync;
		t_port;
		report_and_stop;
	end
	initial begin
		#20000;
		error_cnt++;
		report_and_stop;
	end
endmodule // acc_comparator_ctrl_tb_top
`default_nettype wire

/* File: test/acc_props_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module acc_props
	import acc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic [5:0]  port_pins_oe,
	input wire logic        cmp_power_on,
	input wire logic        cmp_speed_normal,
	input wire logic [3:0]  pos_src_enable,
	input wire logic [2:0]  neg_src_enable,
	input wire logic        result_synchronized,
	input wire logic        timer_gate_source,
	input wire logic        comparator_irq_flag
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic clr;
	assign clr = psel && penable && pwrite && paddr == ADDR_IRQ && pwdata[0];
	property p_src_off; !cmp_power_on && !$past(cmp_power_on) |-> !pos_src_enable && !neg_src_enable; endproperty
	a_src_off: assert property (p_src_off) else $error("source live while off");
	property p_pos; $onehot0(pos_src_enable); endproperty
	a_pos: assert property (p_pos) else $error("positive select not one-hot");
	property p_neg; $onehot0(neg_src_enable); endproperty
	a_neg: assert property (p_neg) else $error("negative select not one-hot");
	// Shadow of the output enable bit, to tell result drive from plain port drive
	logic oe_shadow_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_shadow_reg <= 1'b0;
		end else if (psel && penable && pwrite && pready && paddr == ADDR_CTRL0 && pstrb[0]) begin
			oe_shadow_reg <= pwdata[C0_OE];
		end
	end
	property p_pin; $past(oe_shadow_reg) && port_pins_oe[2] |-> cmp_power_on; endproperty
	a_pin: assert property (p_pin) else $error("result pin driven while off");
	property p_gate; timer_gate_source == result_synchronized; endproperty
	a_gate: assert property (p_gate) else $error("gate source differs");
	property p_flag; comparator_irq_flag && !clr && !$past(clr) |=> comparator_irq_flag; endproperty
	a_flag: assert property (p_flag) else $error("flag lost without clear");
	property p_speed; $rose(presetn) |-> cmp_speed_normal && !cmp_power_on; endproperty
	a_speed: assert property (p_speed) else $error("speed reset value wrong");
	property p_mirror; pready && !pwrite && paddr == ADDR_MIRROR |-> prdata[31:1] == 31'h0; endproperty
	a_mirror: assert property (p_mirror) else $error("mirror upper bits set");
endmodule // acc_props
bind acc_comparator_ctrl acc_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .port_pins_oe, .cmp_power_on, .cmp_speed_normal, .pos_src_enable,
	.neg_src_enable, .result_synchronized, .timer_gate_source, .comparator_irq_flag);
`default_nettype wire
